// file: rtl/mgsi_blink.sv
module mgsi_blink
   import mgsi_pkg::*;
#(
   parameter int TICK_CYCLES = mgsi_pkg::TICK_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   mgsi_led_if.gen led
);
   localparam int TW = $clog2(TICK_CYCLES + 1);

   typedef enum logic [1:0] {
      ST_ON = 2'b01,
      ST_OFF = 2'b10
   } mgsi_blink_t;

   mgsi_blink_t st_ff, nxt_st;
   logic [TW-1:0] tick_cnt_ff;
   logic [1:0] sec_ff, nxt_sec;
   logic [2:0] prev_ff;
   logic led_ff, nxt_led;
   logic tick, restart;
   logic [1:0] sec_inc;

   if (TICK_CYCLES < 2) begin : g_bad_tick
      $error("mgsi_blink: TICK_CYCLES must be at least 2");
   end

   assign tick = tick_cnt_ff == TW'(TICK_CYCLES - 1);
   assign restart = led.net_state != prev_ff;
   assign sec_inc = sec_ff + 2'h1;
   assign led.led_on = led_ff;

   always_comb begin
      nxt_st = st_ff;
      nxt_sec = sec_ff;
      if (restart) begin
         nxt_st = ST_ON;
         nxt_sec = 2'h0;
      end else if (tick) begin
         nxt_sec = sec_inc;
         unique case (st_ff)
            ST_ON: begin
               if (sec_inc == LED_ON_S) begin
                  nxt_st = ST_OFF;
                  nxt_sec = 2'h0;
               end
            end
            ST_OFF: begin
               if (sec_inc == LED_OFF_S) begin
                  nxt_st = ST_ON;
                  nxt_sec = 2'h0;
               end
            end
            default: begin
               nxt_st = ST_ON;
               nxt_sec = 2'h0;
            end
         endcase
      end
   end

   always_comb begin
      unique case (led.net_state)
         NET_UNREG, NET_VOICE: nxt_led = 1'b1;
         NET_IDLE, NET_DIAL: nxt_led = nxt_st == ST_ON;
         NET_PSAVE: nxt_led = led.wake;
         default: nxt_led = 1'b0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_ff <= ST_ON;
         sec_ff <= 2'h0;
         tick_cnt_ff <= '0;
         prev_ff <= NET_OFF;
         led_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         sec_ff <= nxt_sec;
         tick_cnt_ff <= (restart || tick) ? '0 : tick_cnt_ff + TW'(1);
         prev_ff <= led.net_state;
         led_ff <= nxt_led;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   property p_restart;
      @(posedge clk) disable iff (!rst_n)
      restart |=> st_ff == ST_ON && sec_ff == 2'h0 && tick_cnt_ff == '0;
   endproperty
   a_restart: assert property (p_restart) else $error("pattern did not restart");

   property p_on_len;
      @(posedge clk) disable iff (!rst_n)
      (!restart && tick && st_ff == ST_ON && sec_inc == LED_ON_S) |=> st_ff == ST_OFF;
   endproperty
   a_on_len: assert property (p_on_len) else $error("on phase not one second");
endmodule : mgsi_blink

// file: rtl/mgsi_led_if.sv
interface mgsi_led_if;
   logic [2:0] net_state;
   logic wake;
   logic led_on;
   modport ctl (output net_state, output wake, input led_on);
   modport gen (input net_state, input wake, output led_on);
endinterface : mgsi_led_if

// file: rtl/mgsi_pkg.sv
package mgsi_pkg;
   // ************************************************************
   // sizes
   // ************************************************************
   localparam int NUM_GP = 8;
   localparam int NUM_FO = 4;
   localparam int NUM_FI = 2;
   localparam int NUM_IN = NUM_GP + NUM_FO + NUM_FI;
   localparam int LED_PAD = 7;
   localparam int ADDR_W = 8;

   // ************************************************************
   // register offsets
   // ************************************************************
   localparam logic [7:0] OFS_GP_MODE = 8'h00;
   localparam logic [7:0] OFS_GP_VAL = 8'h04;
   localparam logic [7:0] OFS_GP_PULL = 8'h08;
   localparam logic [7:0] OFS_FLOW_CFG = 8'h0C;
   localparam logic [7:0] OFS_PAD_IN = 8'h10;
   localparam logic [7:0] OFS_NET_STATE = 8'h14;
   localparam logic [7:0] OFS_CARD_CFG = 8'h18;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
   localparam logic [7:0] OFS_CARD_STAT = 8'h24;

   // ************************************************************
   // fields and encodings
   // ************************************************************
   localparam logic [1:0] MODE_IN = 2'h0;
   localparam logic [1:0] MODE_OUT = 2'h1;
   localparam logic [1:0] MODE_ALT = 2'h2;
   localparam logic [1:0] PULL_UP = 2'h1;
   localparam logic [1:0] PULL_DOWN = 2'h2;
   localparam int FLOW_IN_ALT_POS = 8;
   localparam int CARD_EN_POS = 4;
   localparam logic [1:0] CARD_EN_VAL = 2'h2;
   localparam int IRQ_CARD = 0;
   localparam int IRQ_REJECT = 1;
   localparam int IRQ_INPUT = 2;
   localparam int IRQ_W = 3;

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [15:0] GP_MODE_RST = 16'h0000;
   localparam logic [11:0] GP_VAL_RST = 12'h000;
   localparam logic [15:0] GP_PULL_RST = 16'h0000;
   localparam logic [9:0] FLOW_CFG_RST = 10'h000;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

   typedef enum logic [2:0] {
      NET_OFF = 3'h0,
      NET_UNREG = 3'h1,
      NET_IDLE = 3'h2,
      NET_PSAVE = 3'h3,
      NET_VOICE = 3'h4,
      NET_DIAL = 3'h5
   } mgsi_net_t;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_KHZ = 125000;
   localparam int TICK_PERIOD_MS = 1000;
   localparam int TICK_CYCLES = TICK_PERIOD_MS * CLK_KHZ;
   localparam logic [1:0] LED_ON_S = 2'h1;
   localparam logic [1:0] LED_OFF_S = 2'h2;
endpackage : mgsi_pkg

// file: rtl/mgsi_sync.sv
module mgsi_sync #(
   parameter int W = 14
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] raw,
   output logic [W-1:0] stable
);
   logic [W-1:0] s1_ff, s2_ff, s3_ff, stable_ff;
   logic [W-1:0] agree;

   if (W < 1) begin : g_bad_w
      $error("mgsi_sync: W must be at least 1");
   end

   // a bit moves only once two later stages agree, so power-up glitches die here
   assign agree = ~(s2_ff ^ s3_ff);
   assign stable = stable_ff;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         stable_ff <= '0;
      end else begin
         s1_ff <= raw;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         stable_ff <= (agree & s3_ff) | (~agree & stable_ff);
      end
   end
endmodule : mgsi_sync

// file: rtl/mgsi_top.sv
// Function
// - each general pad's pull-up or pull-down is software selectable.
// - flow-control pins may be used as plain I/O instead of handshake.
// - four flow output pads default input, hold 0 in reset and on/off.
// - two flow input pads default input, hold 0 in reset and on/off.
// - an input pad reports the level an external output drives.
// - an output pad drives push-pull, both levels.
// - status indicator is pad 7 alternate function, enabled only there.
// - status pin is the inverse of the LED state.
// - LED off when off, on unregistered or voice, 1s on 2s off idle.
// - dial-up blinks 1 s on, 2 s off.
// - power saving idle: LED follows the paging wake-up event.
// - any general pad can be the card-presence detect input.
// - card detect is enabled by enable value 2.
// - a pad read returns the level present at read time.
// - alternate-function pads are driven by internal logic only.
//
// Added by the designer: the register addresses and the APB slave port.
module mgsi_top
   import mgsi_pkg::*;
#(
   parameter int TICK_CYCLES = mgsi_pkg::TICK_CYCLES
) (
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [mgsi_pkg::ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [mgsi_pkg::NUM_GP-1:0] GP_PAD_IN,
   output logic [mgsi_pkg::NUM_GP-1:0] GP_PAD_OUT,
   output logic [mgsi_pkg::NUM_GP-1:0] GP_PAD_OE,
   output logic [mgsi_pkg::NUM_GP-1:0] GP_PULL_UP,
   output logic [mgsi_pkg::NUM_GP-1:0] GP_PULL_DOWN,
   input wire logic [mgsi_pkg::NUM_FO-1:0] FLOW_OUT_PAD_IN,
   output logic [mgsi_pkg::NUM_FO-1:0] FLOW_OUT_PAD_OUT,
   output logic [mgsi_pkg::NUM_FO-1:0] FLOW_OUT_PAD_OE,
   input wire logic [mgsi_pkg::NUM_FI-1:0] FLOW_IN_PAD,
   input wire logic [mgsi_pkg::NUM_FO-1:0] HS_OUT_SRC,
   output logic [mgsi_pkg::NUM_FI-1:0] HS_IN_DST,
   input wire logic ONOFF_SEQ,
   input wire logic WAKE_PAGING,
   output logic IRQ
);
   // ************************************************************
   // registers
   // ************************************************************
   logic [15:0] gp_mode_ff, gp_pull_ff;
   logic [11:0] gp_val_ff;
   logic [9:0] flow_cfg_ff;
   logic [2:0] net_ff, card_sel_ff;
   logic [1:0] card_en_ff;
   logic [IRQ_W-1:0] irq_ff, mask_ff, nxt_irq;
   logic card_ff, irq_o_ff, pready_ff, pslverr_ff;
   logic [31:0] prdata_ff;
   logic [NUM_IN-1:0] in_stable, in_prev_ff;
   logic [NUM_GP-1:0] gp_out_ff, gp_oe_ff, pu_ff, pd_ff, nxt_gp_out, nxt_gp_oe, nxt_pu, nxt_pd;
   logic [NUM_FO-1:0] fo_out_ff, fo_oe_ff, nxt_fo_out, nxt_fo_oe;
   logic [NUM_FI-1:0] hs_in_ff, nxt_hs_in;

   function automatic logic [1:0] pad_mode(input logic [15:0] m, input logic [2:0] i);
      return m[{i, 1'b0} +: 2];
   endfunction : pad_mode

   mgsi_led_if led_if ();
   assign led_if.net_state = net_ff;
   assign led_if.wake = WAKE_PAGING;

   mgsi_blink #(.TICK_CYCLES(TICK_CYCLES)) u_blink (
      .clk(CLOCK),
      .rst_n(RST_N),
      .led(led_if)
   );

   mgsi_sync #(.W(NUM_IN)) u_sync (
      .clk(CLOCK),
      .rst_n(RST_N),
      .raw({FLOW_IN_PAD, FLOW_OUT_PAD_IN, GP_PAD_IN}),
      .stable(in_stable)
   );

   // ************************************************************
   // apb decode
   // ************************************************************
   // one wait state: data is captured in the first access cycle, ready in the second
   wire access = PSEL & PENABLE;
   wire first = access & ~pready_ff;
   wire done = access & pready_ff;
   wire wr_done = done & PWRITE;
   wire rd_done = done & ~PWRITE;
   wire sel_mode = PADDR == OFS_GP_MODE;
   wire sel_val = PADDR == OFS_GP_VAL;
   wire sel_pull = PADDR == OFS_GP_PULL;
   wire sel_flow = PADDR == OFS_FLOW_CFG;
   wire sel_pin = PADDR == OFS_PAD_IN;
   wire sel_net = PADDR == OFS_NET_STATE;
   wire sel_card = PADDR == OFS_CARD_CFG;
   wire sel_stat = PADDR == OFS_IRQ_STAT;
   wire sel_mask = PADDR == OFS_IRQ_MASK;
   wire sel_cst = PADDR == OFS_CARD_STAT;
   wire mapped = sel_mode | sel_val | sel_pull | sel_flow | sel_pin | sel_net | sel_card | sel_stat
      | sel_mask | sel_cst;
   wire [31:0] rd_val =
      sel_mode ? {16'h0000, gp_mode_ff} :
      sel_val ? {20'h00000, gp_val_ff} :
      sel_pull ? {16'h0000, gp_pull_ff} :
      sel_flow ? {22'h0, flow_cfg_ff} :
      sel_pin ? {18'h0, in_stable} :
      sel_net ? {29'h0, net_ff} :
      sel_card ? {26'h0, card_en_ff, 1'b0, card_sel_ff} :
      sel_stat ? {29'h0, irq_ff} :
      sel_mask ? {29'h0, mask_ff} :
      sel_cst ? {31'h0, card_ff} : 32'h00000000;

   // ************************************************************
   // card detect and exclusivity
   // ************************************************************
   wire card_on = card_en_ff == CARD_EN_VAL;
   wire nxt_card = card_on & in_stable[card_sel_ff];
   // a mode write that leaves the detect pad anything but input is dropped whole
   wire mode_rej = wr_done & sel_mode & card_on & (pad_mode(PWDATA[15:0], card_sel_ff) != MODE_IN);
   wire card_rej = wr_done & sel_card & (PWDATA[CARD_EN_POS +: 2] == CARD_EN_VAL)
      & (pad_mode(gp_mode_ff, PWDATA[2:0]) != MODE_IN);
   wire [IRQ_W-1:0] ev;
   assign ev[IRQ_CARD] = nxt_card != card_ff;
   assign ev[IRQ_REJECT] = mode_rej | card_rej;
   assign ev[IRQ_INPUT] = in_stable != in_prev_ff;
   // only bits that the read returned are cleared: an event landing after the data was
   // captured would otherwise vanish unseen; set still beats the clear in the same cycle
   wire [IRQ_W-1:0] rd_clr = {IRQ_W{rd_done & sel_stat}} & prdata_ff[IRQ_W-1:0];
   assign nxt_irq = (irq_ff & ~rd_clr) | ev;

   // ************************************************************
   // pad drive
   // ************************************************************
   for (genvar i = 0; i < NUM_GP; i++) begin : g_gp
      wire [1:0] m = gp_mode_ff[2 * i +: 2];
      wire led_alt = (i == LED_PAD) && (m == MODE_ALT);
      assign nxt_gp_oe[i] = ~ONOFF_SEQ & ((m == MODE_OUT) | led_alt);
      assign nxt_gp_out[i] = ~ONOFF_SEQ & (led_alt ? ~led_if.led_on : (m == MODE_OUT) & gp_val_ff[i]);
      assign nxt_pu[i] = gp_pull_ff[2 * i +: 2] == PULL_UP;
      assign nxt_pd[i] = gp_pull_ff[2 * i +: 2] == PULL_DOWN;
   end
   for (genvar j = 0; j < NUM_FO; j++) begin : g_fo
      wire [1:0] m = flow_cfg_ff[2 * j +: 2];
      assign nxt_fo_oe[j] = ~ONOFF_SEQ & ((m == MODE_OUT) | (m == MODE_ALT));
      assign nxt_fo_out[j] = ~ONOFF_SEQ & ((m == MODE_ALT) ? HS_OUT_SRC[j] : (m == MODE_OUT) & gp_val_ff[NUM_GP + j]);
   end
   for (genvar k = 0; k < NUM_FI; k++) begin : g_fi
      // handshake side sees 0 unless the pad is handed to it
      assign nxt_hs_in[k] = ~ONOFF_SEQ & flow_cfg_ff[FLOW_IN_ALT_POS + k] & in_stable[NUM_GP + NUM_FO + k];
   end

   // ************************************************************
   // state
   // ************************************************************
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         gp_mode_ff <= GP_MODE_RST;
         gp_val_ff <= GP_VAL_RST;
         gp_pull_ff <= GP_PULL_RST;
         flow_cfg_ff <= FLOW_CFG_RST;
         net_ff <= NET_OFF;
         card_sel_ff <= 3'h0;
         card_en_ff <= 2'h0;
         mask_ff <= IRQ_MASK_RST;
      end else if (wr_done) begin
         if (sel_mode && !mode_rej) gp_mode_ff <= PWDATA[15:0];
         if (sel_val) gp_val_ff <= PWDATA[11:0];
         if (sel_pull) gp_pull_ff <= PWDATA[15:0];
         if (sel_flow) flow_cfg_ff <= PWDATA[9:0];
         if (sel_net) net_ff <= PWDATA[2:0];
         if (sel_card && !card_rej) begin
            card_sel_ff <= PWDATA[2:0];
            card_en_ff <= PWDATA[CARD_EN_POS +: 2];
         end
         if (sel_mask) mask_ff <= PWDATA[IRQ_W-1:0];
      end
   end

   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         irq_ff <= '0;
         card_ff <= 1'b0;
         in_prev_ff <= '0;
         irq_o_ff <= 1'b0;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h00000000;
      end else begin
         irq_ff <= nxt_irq;
         card_ff <= nxt_card;
         in_prev_ff <= in_stable;
         irq_o_ff <= |(irq_ff & mask_ff);
         pready_ff <= first;
         pslverr_ff <= first & ~mapped;
         if (first && !PWRITE) prdata_ff <= rd_val;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         gp_out_ff <= '0;
         gp_oe_ff <= '0;
         fo_out_ff <= '0;
         fo_oe_ff <= '0;
         hs_in_ff <= '0;
         pu_ff <= '0;
         pd_ff <= '0;
      end else begin
         gp_out_ff <= nxt_gp_out;
         gp_oe_ff <= nxt_gp_oe;
         fo_out_ff <= nxt_fo_out;
         fo_oe_ff <= nxt_fo_oe;
         hs_in_ff <= nxt_hs_in;
         pu_ff <= nxt_pu;
         pd_ff <= nxt_pd;
      end
   end

   assign PRDATA = prdata_ff;
   assign PREADY = pready_ff;
   assign PSLVERR = pslverr_ff;
   assign GP_PAD_OUT = gp_out_ff;
   assign GP_PAD_OE = gp_oe_ff;
   assign GP_PULL_UP = pu_ff;
   assign GP_PULL_DOWN = pd_ff;
   assign FLOW_OUT_PAD_OUT = fo_out_ff;
   assign FLOW_OUT_PAD_OE = fo_oe_ff;
   assign HS_IN_DST = hs_in_ff;
   assign IRQ = irq_o_ff;

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_N);

   property p_onoff_low;
      ONOFF_SEQ |=> FLOW_OUT_PAD_OE == '0 && FLOW_OUT_PAD_OUT == '0 && GP_PAD_OE == '0 && GP_PAD_OUT == '0;
   endproperty
   a_onoff_low: assert property (p_onoff_low) else $error("pads not low in on/off");

   property p_fi_hold;
      !flow_cfg_ff[FLOW_IN_ALT_POS] |=> HS_IN_DST[0] == 1'b0;
   endproperty
   a_fi_hold: assert property (p_fi_hold) else $error("flow input leaked while gpio");

   property p_push_pull;
      (pad_mode(gp_mode_ff, 3'h0) == MODE_OUT && !ONOFF_SEQ) |=> GP_PAD_OE[0] && GP_PAD_OUT[0] == $past(gp_val_ff[0]);
   endproperty
   a_push_pull: assert property (p_push_pull) else $error("output pad not driven");

   property p_led_inv;
      (pad_mode(gp_mode_ff, 3'h7) == MODE_ALT && !ONOFF_SEQ) |=> GP_PAD_OE[LED_PAD] && GP_PAD_OUT[LED_PAD] == !$past(led_if.led_on);
   endproperty
   a_led_inv: assert property (p_led_inv) else $error("status pin not inverse of led");

   property p_led_only_alt;
      (pad_mode(gp_mode_ff, 3'h7) == MODE_IN) |=> !GP_PAD_OE[LED_PAD];
   endproperty
   a_led_only_alt: assert property (p_led_only_alt) else $error("status pin driven while input");

   property p_unreg_on;
      (net_ff == NET_UNREG) [*2] |-> led_if.led_on;
   endproperty
   a_unreg_on: assert property (p_unreg_on) else $error("led not on when unregistered");

   property p_off_dark;
      (net_ff == NET_OFF) [*2] |-> !led_if.led_on;
   endproperty
   a_off_dark: assert property (p_off_dark) else $error("led lit while device off");

   property p_psave;
      (net_ff == NET_PSAVE) [*2] |-> led_if.led_on == $past(WAKE_PAGING);
   endproperty
   a_psave: assert property (p_psave) else $error("led not following wake event");

   property p_pin_read;
      (first && !PWRITE && sel_pin) |=> PREADY && PRDATA[NUM_IN-1:0] == $past(in_stable);
   endproperty
   a_pin_read: assert property (p_pin_read) else $error("pad read not current level");

   property p_card_rej;
      card_rej |=> card_en_ff == $past(card_en_ff) && irq_ff[IRQ_REJECT];
   endproperty
   a_card_rej: assert property (p_card_rej) else $error("conflicting detect config taken");

   property p_irq_level;
      1'b1 |=> IRQ == $past(|(irq_ff & mask_ff));
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("irq output not following masked status");

   property p_set_wins;
      ev[IRQ_REJECT] |=> irq_ff[IRQ_REJECT];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("refused config left no status bit");

   c_blink: cover property (net_ff == NET_IDLE && $fell(led_if.led_on));
   c_card: cover property (card_on && $rose(card_ff));
   c_reject: cover property (mode_rej);
   c_card_rej: cover property (card_rej);
endmodule : mgsi_top

// file: tb/mgsi_far_side.sv
module mgsi_far_side (
   input wire logic clk,
   input wire logic [7:0] gp_out,
   input wire logic [7:0] gp_oe,
   input wire logic [7:0] pu,
   input wire logic [7:0] pd,
   input wire logic [7:0] ext_val,
   input wire logic [7:0] ext_en,
   input wire logic [3:0] fo_out,
   input wire logic [3:0] fo_oe,
   output logic [7:0] gp_lvl,
   output logic [3:0] fo_lvl,
   output logic led_lit
);
   timeunit 1ns;
   timeprecision 1ps;
   // ************************************************************
   // pad wires
   // ************************************************************
   // an undriven pad without pull wanders every cycle, so a stale value never passes
   logic fl = 1'b0;
   always @(posedge clk) begin
      fl <= ~fl;
   end
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         gp_lvl[i] = gp_oe[i] ? gp_out[i] : ext_en[i] ? ext_val[i] : pu[i] ? 1'b1 : pd[i] ? 1'b0 : fl;
      end
      fo_lvl = (fo_oe & fo_out) | (~fo_oe & {4{fl}});
   end
   // transistor inverts the pin; a pin not driven lights nothing, glitches ignored
   assign led_lit = gp_oe[7] & ~gp_out[7];
endmodule : mgsi_far_side

// file: tb/mgsi_top_tb.sv
module mgsi_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import mgsi_pkg::*;
   typedef struct {logic [2:0] st; logic wk; int on;} mgsi_row_t;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdv;
   logic pready, pslverr, erv, irq, onoff = 1'b0, wake = 1'b0, led;
   logic [7:0] gp_in, gp_out, gp_oe, pu, pd, ext_val = 8'h00, ext_en = 8'h00;
   logic [3:0] fo_in, fo_out, fo_oe, hs_src = 4'h0;
   logic [1:0] fi_pad = 2'h0, hs_dst;
   int num_errors = 0, tests_run = 0, n;
   mgsi_row_t rows[7] = '{'{NET_OFF, 0, 0}, '{NET_UNREG, 0, 24}, '{NET_IDLE, 0, 8},
      '{NET_PSAVE, 1, 24}, '{NET_PSAVE, 0, 0}, '{NET_VOICE, 0, 24}, '{NET_DIAL, 0, 8}};
   always #4 clk = ~clk;
   mgsi_top #(.TICK_CYCLES(8)) mgsi_top_i (.CLOCK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .GP_PAD_IN(gp_in), .GP_PAD_OUT(gp_out), .GP_PAD_OE(gp_oe), .GP_PULL_UP(pu), .GP_PULL_DOWN(pd),
      .FLOW_OUT_PAD_IN(fo_in), .FLOW_OUT_PAD_OUT(fo_out), .FLOW_OUT_PAD_OE(fo_oe), .FLOW_IN_PAD(fi_pad),
      .HS_OUT_SRC(hs_src), .HS_IN_DST(hs_dst), .ONOFF_SEQ(onoff), .WAKE_PAGING(wake), .IRQ(irq));
   mgsi_far_side mgsi_far_side_i (.clk(clk), .gp_out(gp_out), .gp_oe(gp_oe), .pu(pu), .pd(pd),
      .ext_val(ext_val), .ext_en(ext_en), .fo_out(fo_out), .fo_oe(fo_oe), .gp_lvl(gp_in), .fo_lvl(fo_in),
      .led_lit(led));
   // ************************************************************
   // helpers
   // ************************************************************
   task report_and_stop();
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : report_and_stop
   task chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_word
   task chk_cnt(input string what, input int exp, input int got);
      tests_run++;
      if (got != exp) begin
         num_errors++;
         $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
      end
   endtask : chk_cnt
   // outputs are looked at mid-cycle, clear of the edge updates
   task cyc(input int k);
      repeat (k) @(posedge clk);
      @(negedge clk);
   endtask : cyc
   // waits as long as the slave wants; only the watchdog ends a hung transfer
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rdv = prdata;
      erv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      report_and_stop();
   end
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      cyc(1);
      chk_word("oe", 32'h0, {fo_oe, gp_oe, hs_dst, irq});
      apb(1'b0, OFS_GP_MODE, 32'h0);
      chk_word("mode rst", 32'h0, rdv);
      apb(1'b1, OFS_GP_PULL, 32'h0000_0009);
      cyc(2);
      chk_word("pull", 32'h3, {pd[1], pu[0]});
      @(posedge clk);
      ext_en <= 8'h02;
      ext_val <= 8'h02;
      fi_pad <= 2'h1;
      hs_src <= 4'h2;
      apb(1'b1, OFS_GP_VAL, 32'h0000_0101);
      apb(1'b1, OFS_GP_MODE, 32'h0000_8001);
      apb(1'b1, OFS_FLOW_CFG, 32'h0000_0309);
      cyc(6);
      chk_word("gp drive", 32'h3, {gp_oe[0], gp_out[0]});
      apb(1'b0, OFS_PAD_IN, 32'h0);
      chk_word("pad in", 32'h3, rdv & 32'h3);
      chk_word("flow a", 32'h3, {fo_oe[0], fo_out[0]});
      chk_word("flow b", 32'h3, {fo_oe[1], fo_out[1]});
      chk_word("hs in", 32'h1, hs_dst);
      @(posedge clk);
      onoff <= 1'b1;
      cyc(1);
      chk_word("onoff", 32'h0, {fo_oe, gp_oe, fo_out, gp_out});
      @(posedge clk);
      onoff <= 1'b0;
      ext_en <= 8'h00;
      foreach (rows[i]) begin
         @(posedge clk);
         wake <= rows[i].wk;
         apb(1'b1, OFS_NET_STATE, {29'h0, rows[i].st});
         cyc(30);
         n = 0;
         repeat (24) begin
            cyc(1);
            n += (led === 1'b1);
         end
         chk_cnt("led", rows[i].on, n);
         chk_word("led oe", 32'h1, gp_oe[7]);
      end
      apb(1'b1, OFS_NET_STATE, 32'h0);
      apb(1'b1, OFS_IRQ_MASK, 32'h0000_0002);
      ext_en <= 8'h04;
      ext_val <= 8'h04;
      // the detect pad stays an input, so the configuration is legal
      apb(1'b1, OFS_CARD_CFG, 32'h0000_0022);
      cyc(6);
      apb(1'b0, OFS_CARD_STAT, 32'h0);
      chk_word("card", 32'h1, rdv & 32'h1);
      apb(1'b1, OFS_GP_MODE, 32'h0000_8011);
      apb(1'b0, OFS_GP_MODE, 32'h0);
      chk_word("refused", 32'h0000_8001, rdv);
      cyc(2);
      chk_word("irq", 32'h1, irq);
      apb(1'b0, OFS_IRQ_STAT, 32'h0);
      chk_word("stat", 32'h2, rdv & 32'h2);
      cyc(3);
      chk_word("irq clr", 32'h0, irq);
      // detect on a pad that is an output must be dropped whole
      apb(1'b1, OFS_CARD_CFG, 32'h0000_0020);
      apb(1'b0, OFS_CARD_CFG, 32'h0);
      chk_word("card refused", 32'h0000_0022, rdv);
      chk_word("irq card", 32'h1, irq);
      apb(1'b0, 8'h40, 32'h0);
      chk_word("unmapped data", 32'h0, rdv);
      chk_word("unmapped err", 32'h1, erv);
      rst_n <= 1'b0;
      cyc(2);
      chk_word("rerst", 32'h0, {fo_oe, gp_oe, irq});
      @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, OFS_GP_MODE, 32'h0);
      chk_word("mode rerst", 32'h0, rdv);
      report_and_stop();
   end
endmodule : mgsi_top_tb
